// ---- rtl/ulpi_phy_bus.sv ----
/*
  Transceiver-side ULPI bus engine: bus ownership, turn-around,
  command decode, register access, transmit throttling and receive.
  Assumes ulpi_clk is the 60 MHz interface clock and clk the core
  clock; streams to and from the core cross by toggle handshakes.
*/
`timescale 1ns/10ps
module ulpi_phy_bus (
  // Core clock domain
  input  wire logic                  clk,
  input  wire logic                  rst_b,
  input  wire logic                  clk_en,
  // ULPI pins
  input  wire logic                  ulpi_clk,
  input  wire logic [7:0]            data_in,
  output logic      [7:0]            data_out,
  output logic                       data_oe,
  output logic                       dir,
  output logic                       nxt,
  input  wire logic                  stp,
  // Transceiver status
  input  wire logic                  pll_ok,
  input  wire ulpi_pkg::mode_t       mode,
  // Transmit stream toward the USB transmitter
  output ulpi_pkg::stream_word_t     tx_word,
  output logic                       tx_valid,
  input  wire logic                  tx_ready,
  // Receive stream from the USB receiver
  input  wire ulpi_pkg::stream_word_t rx_word,
  input  wire logic                  rx_valid,
  output logic                       rx_ack,
  // Settings and control
  output ulpi_pkg::settings_t        settings,
  output logic                       se_rx_en,
  output logic                       wake
);
  import ulpi_pkg::*;

  typedef enum logic [3:0] {
    ST_IDLE   = 4'h0,
    ST_CMD    = 4'h1,
    ST_TX     = 4'h3,
    ST_TX_END = 4'h2,
    ST_WR     = 4'h6,
    ST_WR_END = 4'h7,
    ST_RD_TA  = 4'h5,
    ST_RD_DRV = 4'h4,
    ST_RX_TA  = 4'hC,
    ST_RX     = 4'hD,
    ST_HOLD   = 4'hF
  } state_t;

  // ----------------------------------------------------------------
  // Link domain reset and crossings
  // ----------------------------------------------------------------
  logic [1:0]   lrst_q;
  logic         lrst_b;
  logic [2:0]   stat_s;
  logic         pll_s;
  mode_t        mode_s;
  logic         tx_ack_s;
  logic         rx_req_s;
  logic         tx_req_q;
  logic         rx_seen_q;
  logic         tx_seen_q;
  logic         rx_req_q;
  stream_word_t txw_q;
  stream_word_t rxw_q;

  // Reset asserts at once, releases on the link clock
  always_ff @(posedge ulpi_clk or negedge rst_b) begin
    if (!rst_b) begin
      lrst_q <= 2'h0;
    end else begin
      lrst_q <= {lrst_q[0], 1'b1};
    end
  end
  assign lrst_b = lrst_q[1];

  ulpi_sync #(.W(SYNC_W)) u_stat_sync (
    .clk   (ulpi_clk),
    .rst_b (lrst_b),
    .en    (1'b1),
    .d     ({pll_ok, mode}),
    .q     (stat_s)
  );
  assign pll_s  = stat_s[2];
  assign mode_s = mode_t'(stat_s[1:0]);

  ulpi_sync #(.W(2)) u_link_hs_sync (
    .clk   (ulpi_clk),
    .rst_b (lrst_b),
    .en    (1'b1),
    .d     ({tx_seen_q, rx_req_q}),
    .q     ({tx_ack_s, rx_req_s})
  );

  // ----------------------------------------------------------------
  // Link domain bus engine
  // ----------------------------------------------------------------
  state_t     st_q;
  logic       dir_q;
  logic       dir_d1_q;
  logic       nxt_q;
  logic       oe_q;
  logic [7:0] dout_q;
  logic [7:0] cmd_q;
  logic [7:0] wdata_q;
  logic       rx_last_q;
  logic       reg_we_q;
  logic [7:0] rd_data;
  logic [7:0] pend_q;
  logic       pend_v_q;
  logic       hold_req;
  logic       ta;
  logic       rx_new;
  logic       rx_take;
  logic       tx_busy;
  logic       tx_accept;
  logic       tx_push;
  logic [1:0] cls;

  // Not able to take link data: PLL not locked or bus reassigned
  // hold request
  assign hold_req  = !pll_s || (mode_s != MODE_SYNC);
  // Cycle right after a direction change is the turn-around
  assign ta        = dir_q != dir_d1_q;
  assign rx_new    = rx_req_s != rx_seen_q;
  assign rx_take   = rx_new && (st_q == ST_RX_TA || (st_q == ST_RX && !rx_last_q));
  assign tx_busy   = tx_req_q != tx_ack_s;
  assign tx_accept = (st_q == ST_TX) && !stp && nxt_q;
  assign tx_push   = (tx_accept || (st_q == ST_TX_END && !tx_busy)) && pend_v_q;
  assign cls       = cmd_q[7:6];

  // Direction history for turn-around detection
  always_ff @(posedge ulpi_clk or negedge lrst_b) begin
    if (!lrst_b) begin
      dir_d1_q <= 1'b1;
    end else begin
      dir_d1_q <= dir_q;
    end
  end

  // Main engine; every pin launched on the rising edge
  // rising edge
  always_ff @(posedge ulpi_clk or negedge lrst_b) begin
    if (!lrst_b) begin
      st_q      <= ST_HOLD;
      dir_q     <= 1'b1;
      nxt_q     <= 1'b0;
      oe_q      <= 1'b0;
      dout_q    <= BUS_IDLE;
      cmd_q     <= BUS_IDLE;
      wdata_q   <= BUS_IDLE;
      rx_last_q <= 1'b0;
      rx_seen_q <= 1'b0;
    end else if (hold_req && st_q != ST_HOLD) begin
      // Abort whatever runs and own the bus
      st_q  <= ST_HOLD;
      dir_q <= 1'b1;
      nxt_q <= 1'b0;
      oe_q  <= 1'b0;
    end else begin
      unique case (st_q)
        ST_IDLE: begin
          if (ta) begin
            nxt_q <= 1'b0;
          end else if (rx_new) begin
            dir_q     <= 1'b1;
            rx_last_q <= 1'b0;
            st_q      <= ST_RX_TA;
          end else if (data_in != BUS_IDLE) begin
            cmd_q <= data_in;
            nxt_q <= 1'b1;
            st_q  <= ST_CMD;
          end
        end
        ST_CMD: begin
          unique case (cls)
            CLS_TX: begin
              nxt_q <= 1'b0;
              st_q  <= ST_TX;
            end
            CLS_WR: begin
              nxt_q <= 1'b1;
              st_q  <= ST_WR;
            end
            CLS_RD: begin
              dir_q <= 1'b1;
              nxt_q <= 1'b0;
              st_q  <= ST_RD_TA;
            end
            CLS_IDLE: begin
              nxt_q <= 1'b0;
              st_q  <= ST_IDLE;
            end
          endcase
        end
        ST_TX: begin
          if (stp) begin
            nxt_q <= 1'b0;
            st_q  <= ST_TX_END;
          end else if (nxt_q) begin
            nxt_q <= 1'b0;
          end else begin
            nxt_q <= !tx_busy;
          end
        end
        ST_TX_END: begin
          if (!tx_busy) begin
            st_q <= ST_IDLE;
          end
        end
        ST_WR: begin
          wdata_q <= data_in;
          nxt_q   <= 1'b0;
          st_q    <= ST_WR_END;
        end
        ST_WR_END: begin
          if (stp) begin
            st_q <= ST_IDLE;
          end
        end
        ST_RD_TA: begin
          dout_q <= rd_data;
          oe_q   <= 1'b1;
          st_q   <= ST_RD_DRV;
        end
        ST_RD_DRV: begin
          dir_q <= 1'b0;
          oe_q  <= 1'b0;
          st_q  <= ST_IDLE;
        end
        ST_RX_TA, ST_RX: begin
          if (st_q == ST_RX && rx_last_q) begin
            dir_q <= 1'b0;
            oe_q  <= 1'b0;
            nxt_q <= 1'b0;
            st_q  <= ST_IDLE;
          end else if (rx_take) begin
            dout_q    <= rxw_q.data;
            rx_last_q <= rxw_q.last;
            rx_seen_q <= rx_req_s;
            oe_q      <= 1'b1;
            nxt_q     <= 1'b1;
            st_q      <= ST_RX;
          end else begin
            nxt_q <= 1'b0;
          end
        end
        ST_HOLD: begin
          dout_q <= BUS_IDLE;
          if (hold_req) begin
            oe_q <= dir_q;
          end else begin
            dir_q <= 1'b0;
            oe_q  <= 1'b0;
            st_q  <= ST_IDLE;
          end
        end
        default: begin
          st_q <= ST_HOLD;
        end
      endcase
    end
  end

  // Transmit byte held back one step so stop can mark it last
  // byte before stop
  always_ff @(posedge ulpi_clk or negedge lrst_b) begin
    if (!lrst_b) begin
      pend_q   <= BUS_IDLE;
      pend_v_q <= 1'b0;
      txw_q    <= '0;
      tx_req_q <= 1'b0;
    end else begin
      if (st_q == ST_CMD && cls == CLS_TX && !hold_req) begin
        pend_q   <= {~cmd_q[3:0], cmd_q[3:0]};
        pend_v_q <= cmd_q[5:0] != 6'h00;
      end else if (tx_accept) begin
        pend_q   <= data_in;
        pend_v_q <= 1'b1;
      end else if (st_q == ST_TX_END && !tx_busy) begin
        pend_v_q <= 1'b0;
      end
      if (tx_push) begin
        txw_q    <= '{data: pend_q, last: st_q == ST_TX_END};
        tx_req_q <= ~tx_req_q;
      end
    end
  end

  // ----------------------------------------------------------------
  // Register array and static settings
  // ----------------------------------------------------------------
  // Write lands after stop; blocked outside synchronous mode
  // contents kept
  always_ff @(posedge ulpi_clk or negedge lrst_b) begin
    if (!lrst_b) begin
      reg_we_q <= 1'b0;
    end else begin
      reg_we_q <= (st_q == ST_WR_END) && stp && !hold_req;
    end
  end

  ulpi_regfile #(.AW(ADDR_W), .DW(DATA_W)) u_regs (
    .clk     (ulpi_clk),
    .we      (reg_we_q),
    .waddr   (cmd_q[5:0]),
    .wdata   (wdata_q),
    .raddr   (cmd_q[5:0]),
    .rdata_q (rd_data)
  );

  // Shadow copies drive the analog controls
  // settings from write data
  always_ff @(posedge ulpi_clk or negedge lrst_b) begin
    if (!lrst_b) begin
      settings <= SETTINGS_RST;
    end else if (reg_we_q && cmd_q[5:0] == ADDR_FUNC_CTRL) begin
      settings.xcvr_sel <= wdata_q[FC_XCVR_LSB +: 2];
      settings.term_sel <= wdata_q[FC_TERM_BIT];
      settings.op_mode  <= wdata_q[FC_OPMODE_LSB +: 2];
    end else if (reg_we_q && cmd_q[5:0] == ADDR_OTG_CTRL) begin
      settings.dp_pd <= wdata_q[OTG_DPPD_BIT];
      settings.dm_pd <= wdata_q[OTG_DMPD_BIT];
    end
  end

  assign data_out = dout_q;
  assign data_oe  = oe_q;
  assign dir      = dir_q;
  assign nxt      = nxt_q;

  // ----------------------------------------------------------------
  // Core domain: stream handshakes, wake, receivers
  // ----------------------------------------------------------------
  logic tx_req_s;
  logic rx_ack_s;
  logic stp_s;
  logic stp_d_q;

  ulpi_sync #(.W(3)) u_core_sync (
    .clk   (clk),
    .rst_b (rst_b),
    .en    (clk_en),
    .d     ({tx_req_q, rx_seen_q, stp}),
    .q     ({tx_req_s, rx_ack_s, stp_s})
  );

  // Transmit word captured only once the previous one drained,
  // so the ack back to the link throttles next
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_seen_q <= 1'b0;
      tx_valid  <= 1'b0;
      tx_word   <= '0;
    end else if (clk_en) begin
      if (tx_valid && tx_ready) begin
        tx_valid <= 1'b0;
      end else if (!tx_valid && tx_req_s != tx_seen_q) begin
        tx_word   <= txw_q;
        tx_valid  <= 1'b1;
        tx_seen_q <= tx_req_s;
      end
    end
  end

  // Receive word held stable until the link side has taken it
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rxw_q    <= '0;
      rx_req_q <= 1'b0;
      rx_ack   <= 1'b0;
    end else if (clk_en) begin
      rx_ack <= 1'b0;
      if (rx_valid && !rx_ack && rx_req_q == rx_ack_s) begin
        rxw_q    <= rx_word;
        rx_req_q <= ~rx_req_q;
        rx_ack   <= 1'b1;
      end
    end
  end

  // Stop rising while asynchronous asks for wake-up; the link
  // clock may be stopped then, so this runs on the core clock
  // stop wakes
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      stp_d_q  <= 1'b0;
      wake     <= 1'b0;
      se_rx_en <= 1'b0;
    end else if (clk_en) begin
      stp_d_q  <= stp_s;
      wake     <= (mode != MODE_SYNC) && stp_s && !stp_d_q;
      se_rx_en <= mode != MODE_CARKIT;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  logic [2:0] lat_q;

  // Cycles spent after the last receive byte was driven
  always_ff @(posedge ulpi_clk or negedge lrst_b) begin
    if (!lrst_b) begin
      lat_q <= 3'h0;
    end else if (st_q == ST_RX && rx_last_q) begin
      lat_q <= lat_q + 3'h1;
    end else begin
      lat_q <= 3'h0;
    end
  end

  default clocking cb @(posedge ulpi_clk);
  endclocking
  default disable iff (!lrst_b);

  sequence s_rd_cmd;
    st_q == ST_CMD && cls == CLS_RD && !hold_req;
  endsequence
  sequence s_rd_bus;
    (dir_q && !nxt_q && !oe_q) ##1 (dir_q && oe_q) ##1 (!dir_q && !oe_q);
  endsequence

  a_one_owner: assert property (oe_q |-> dir_q)
    else $error("data driven without direction high");
  a_idle_zero: assert property (
    st_q == ST_IDLE && !hold_req && !ta && !rx_new && data_in == BUS_IDLE
    |=> st_q == ST_IDLE && !nxt_q)
    else $error("idle bus started a transfer");
  a_rx_take: assert property (
    st_q == ST_IDLE && !hold_req && !ta && rx_new |=> dir_q && st_q == ST_RX_TA)
    else $error("direction not raised for receive data");
  a_pll_hold: assert property (hold_req |=> dir_q && !nxt_q)
    else $error("direction low while unable to accept");
  a_stp_write: assert property (
    st_q == ST_WR_END && stp && !hold_req |=> reg_we_q ##1 !reg_we_q)
    else $error("register write not taken on stop");
  a_nxt_throttle: assert property (
    st_q == ST_TX && nxt_q && !stp && !hold_req
    |=> !nxt_q ##1 (st_q != ST_TX || nxt_q == !$past(tx_busy)))
    else $error("next not throttled after a transmit byte");
  a_turn_quiet: assert property (ta |-> !oe_q)
    else $error("bus driven in turn-around");
  a_ta_ignore: assert property (
    st_q == ST_IDLE && ta && !hold_req |=> st_q != ST_CMD)
    else $error("bus read during turn-around");
  a_rx_latency: assert property (lat_q <= RX_END_MAX_CYC)
    else $error("receive end too slow");
  a_read_turn: assert property (s_rd_cmd |=> s_rd_bus)
    else $error("register read bus sequence wrong");
  a_keep_regs: assert property (reg_we_q |-> $past(mode_s) == MODE_SYNC)
    else $error("register written outside synchronous mode");
  a_carkit_se: assert property (
    @(posedge clk) disable iff (!rst_b) clk_en && mode == MODE_CARKIT |=> !se_rx_en)
    else $error("receivers left on in car-kit mode");

endmodule // ulpi_phy_bus

// ---- shared/ulpi_pkg.sv ----
/*
  Package for the transceiver-side ULPI bus logic: command classes,
  modes, register addresses, field positions, reset values and timing.
  Assumes a 60 MHz ULPI clock and a high-speed bit rate of 480 MHz.
*/
package ulpi_pkg;

  // ----------------------------------------------------------------
  // Bus widths and status synchroniser width
  // ----------------------------------------------------------------
  localparam int DATA_W   = 8;
  localparam int ADDR_W   = 6;
  localparam int SYNC_W   = 3;

  // ----------------------------------------------------------------
  // Command byte classes, top two bits of the link's command
  // ----------------------------------------------------------------
  localparam logic [1:0] CLS_IDLE = 2'h0;
  localparam logic [1:0] CLS_TX   = 2'h1;
  localparam logic [1:0] CLS_WR   = 2'h2;
  localparam logic [1:0] CLS_RD   = 2'h3;
  localparam logic [7:0] BUS_IDLE = 8'h00;

  // ----------------------------------------------------------------
  // Setting registers inside the register array
  // ----------------------------------------------------------------
  localparam logic [5:0] ADDR_FUNC_CTRL = 6'h04;
  localparam logic [5:0] ADDR_OTG_CTRL  = 6'h0A;
  localparam int         FC_XCVR_LSB    = 0;
  localparam int         FC_TERM_BIT    = 2;
  localparam int         FC_OPMODE_LSB  = 3;
  localparam int         OTG_DPPD_BIT   = 1;
  localparam int         OTG_DMPD_BIT   = 2;

  // ----------------------------------------------------------------
  // Receive-end latency: high-speed bit clocks to ULPI cycles
  // ----------------------------------------------------------------
  localparam int ULPI_CLK_MHZ   = 60;
  localparam int HS_BIT_MHZ     = 480;
  localparam int RX_END_MAX_HS  = 43;
  localparam int RX_END_MAX_CYC = RX_END_MAX_HS * ULPI_CLK_MHZ / HS_BIT_MHZ;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_SYNC   = 2'h0,
    MODE_LOWPWR = 2'h1,
    MODE_SERIAL = 2'h2,
    MODE_CARKIT = 2'h3
  } mode_t;

  typedef struct packed {
    logic [7:0] data;
    logic       last;
  } stream_word_t;

  typedef struct packed {
    logic [1:0] xcvr_sel;
    logic       term_sel;
    logic [1:0] op_mode;
    logic       dp_pd;
    logic       dm_pd;
  } settings_t;

  localparam settings_t SETTINGS_RST = '0;

endpackage

// ---- rtl/ulpi_sync.sv ----
/*
  Two-stage synchroniser for a group of level or toggle signals.
  Assumes each bit changes slowly or is a toggle, so bits may be
  sampled independently.
*/
`timescale 1ns/10ps
module ulpi_sync #(
  parameter int W = 1
) (
  // Clock, reset, enable
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic         en,
  // Data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_q;

  // First stage is read only by the second stage
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_q <= '0;
      q      <= '0;
    end else if (en) begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule // ulpi_sync

// ---- rtl/ulpi_regfile.sv ----
/*
  Register array of the transceiver, one write and one read port.
  Assumes the caller gates writes by mode; read data is registered
  and follows the read address one cycle later.
*/
`timescale 1ns/10ps
module ulpi_regfile #(
  parameter int AW = 6,
  parameter int DW = 8
) (
  // Clock
  input  wire logic          clk,
  // Write port
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [DW-1:0] wdata,
  // Read port
  input  wire logic [AW-1:0] raddr,
  output logic      [DW-1:0] rdata_q
);

  logic [DW-1:0] mem [2**AW];

  // Write and registered read; no reset so it maps to RAM
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata_q <= mem[raddr];
  end

endmodule // ulpi_regfile

// ---- tb/ulpi_link_model.sv ----
/* Link controller model facing the ULPI bus engine.
   Assumes ulpi_clk comes from the bench and data_in feeds the PHY. */
`timescale 1ns/10ps
module ulpi_link_model (
  // ULPI pins
  input  wire logic       ulpi_clk,
  input  wire logic [7:0] data_out,
  input  wire logic       data_oe,
  input  wire logic       dir,
  input  wire logic       nxt,
  output logic      [7:0] data_in,
  output logic            stp
);
  import ulpi_pkg::*;
  logic [7:0] drv_q = 8'h00;
  logic       own_q = 1'b1;
  logic [7:0] bus_s = 8'h00;
  logic       dir_s = 1'b1;
  logic       nxt_s = 1'b0;
  logic       oe_s  = 1'b0;
  initial stp = 1'b0;
  // Pre-edge samples, so the tasks never race the PHY
  always @(posedge ulpi_clk) begin
    bus_s <= data_in;
    dir_s <= dir;
    nxt_s <= nxt;
    oe_s  <= data_oe;
  end
  // drive only after dir low a full cycle; a free bus toggles
  assign data_in = data_oe ? data_out : (own_q && !dir && !dir_s) ? drv_q : ~bus_s;
  task automatic step();
    @(posedge ulpi_clk);
    #1;
  endtask
  // hold each byte until an edge sees nxt
  task automatic put(input logic [7:0] b);
    while (dir_s !== 1'b0 || dir !== 1'b0) step();
    drv_q = b;
    own_q = 1'b1;
    do step(); while (nxt_s !== 1'b1);
  endtask
  // one-cycle stop, bus back to idle
  task automatic end_pkt();
    drv_q = 8'h00;
    stp = 1'b1;
    step();
    stp = 1'b0;
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    put({CLS_WR, a});
    put(d);
    end_pkt();
  endtask
  // release, take the byte that follows the turn-around
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    put({CLS_RD, a});
    own_q = 1'b0;
    drv_q = 8'h00;
    do step(); while (!(dir_s && oe_s));
    d = bus_s;
    step();
    own_q = 1'b1;
  endtask
  // transmit command, payload, stop after the last byte
  task automatic tx(input logic [3:0] pid, input logic [7:0] b[$]);
    put({CLS_TX, 2'h0, pid});
    foreach (b[i]) put(b[i]);
    end_pkt();
  endtask
  // stop pulse while the link clock is stopped, timed not clocked
  task automatic wake_pulse();
    #1 stp = 1'b1;
    #100 stp = 1'b0;
  endtask
endmodule // ulpi_link_model

// ---- tb/ulpi_phy_bus_protocol_test.sv ----
/* Self-checking bench for the ULPI bus engine and a link model.
   Assumes the package and the link model are compiled first. */
`timescale 1ns/10ps
module ulpi_phy_bus_protocol_test;
  import ulpi_pkg::*;
  logic         clk = 0, ulpi_clk = 0, rst_b = 0, pll_ok = 0;
  logic         tx_ready = 0, rx_valid = 0, ulpi_run = 1;
  logic         rx_ack, tx_valid, data_oe, dir, nxt, stp, se_rx_en, wake;
  logic [7:0]   data_in, data_out, fd, od, rd_v;
  logic [3:0]   pid;
  mode_t        mode = MODE_SYNC;
  stream_word_t tx_word, rx_word = '0;
  settings_t    settings, set_e;
  stream_word_t exp_q[$];
  logic [7:0]   rx_q[$], b_q[$];
  int           miscompares = 0, n_compared = 0, cycles = 0, wakes = 0;

  always #12.5 clk = ~clk;
  // Link clock parks low while ulpi_run is low
  always #24 ulpi_clk = ulpi_run ? ~ulpi_clk : 1'b0;

  ulpi_phy_bus dut (.clk, .rst_b, .clk_en(1'b1), .ulpi_clk, .data_in, .data_out,
    .data_oe, .dir, .nxt, .stp, .pll_ok, .mode, .tx_word, .tx_valid, .tx_ready,
    .rx_word, .rx_valid, .rx_ack, .settings, .se_rx_en, .wake);
  ulpi_link_model link (.ulpi_clk, .data_out, .data_oe, .dir, .nxt, .data_in, .stp);

  task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Hang guard and wake pulse count
  always @(posedge clk) begin
    cycles++;
    if (wake === 1'b1) wakes++;
    if (cycles == 30000) begin
      miscompares++;
      stop_test();
    end
  end

  // Stalling transmitter, random per cycle
  always @(posedge clk) begin
    #2;
    tx_ready = 1'($urandom);
  end

  // Result watchers take the oldest note per result
  always @(posedge clk)
    if (tx_valid === 1'b1 && tx_ready) check("tx_word", tx_word, exp_q.pop_front());
  always @(posedge ulpi_clk)
    if (dir && nxt && data_oe === 1'b1) check("rx byte", data_out, rx_q.pop_front());

  task automatic rx_send(input logic [7:0] b, input logic l);
    @(posedge clk) #2;
    rx_word = '{b, l};
    rx_valid = 1'b1;
    rx_q.push_back(b);
    do @(posedge clk); while (rx_ack !== 1'b1);
    #2 rx_valid = 1'b0;
  endtask

  // Bounded wait for the watchers to empty both queues
  task automatic drain();
    repeat (3000) if (exp_q.size() + rx_q.size() != 0) @(posedge clk);
  endtask

  initial begin
    fd = $urandom(62250);
    repeat (12) @(posedge clk);
    check("dir in reset", dir, 1);
    #2 rst_b = 1'b1;
    repeat (20) @(posedge clk);
    check("dir pll low", dir, 1);
    #2 pll_ok = 1'b1;
    $display("test reset done");
    fd = $urandom;
    od = $urandom;
    link.wr(ADDR_FUNC_CTRL, fd);
    link.wr(ADDR_OTG_CTRL, od);
    repeat (8) @(posedge clk);
    set_e = '{fd[1:0], fd[2], fd[4:3], od[1], od[2]};
    check("settings", settings, set_e);
    link.rd(ADDR_FUNC_CTRL, rd_v);
    check("read func", rd_v, fd);
    link.rd(ADDR_OTG_CTRL, rd_v);
    check("read otg", rd_v, od);
    $display("test registers done");
    // One packet without and one with an identifier
    for (int p = 0; p < 2; p++) begin
      pid = p ? 4'($urandom_range(15, 1)) : 4'h0;
      if (pid != 0) exp_q.push_back(stream_word_t'{{~pid, pid}, 1'b0});
      b_q.delete();
      for (int i = 0; i < 3; i++) begin
        b_q.push_back(8'($urandom));
        exp_q.push_back(stream_word_t'{b_q[i], i == 2});
      end
      link.tx(pid, b_q);
      drain();
    end
    check("tx left", exp_q.size(), 0);
    $display("test transmit done");
    for (int i = 0; i < 3; i++) rx_send(8'($urandom), i == 2);
    drain();
    repeat (6) @(posedge ulpi_clk);
    check("rx left", rx_q.size(), 0);
    check("dir after rx", dir, 0);
    $display("test receive done");
    @(posedge clk) #2 mode = MODE_CARKIT;
    repeat (20) @(posedge clk);
    check("se rx carkit", se_rx_en, 0);
    check("dir async", dir, 1);
    // Stop the link clock: wake must work from the core clock alone
    ulpi_run = 1'b0;
    #2 mode = MODE_LOWPWR;
    repeat (10) @(posedge clk);
    link.wake_pulse();
    repeat (10) @(posedge clk);
    check("wake", wakes, 1);
    check("settings kept", settings, set_e);
    ulpi_run = 1'b1;
    #2 mode = MODE_SYNC;
    repeat (30) @(posedge clk);
    check("se rx sync", se_rx_en, 1);
    check("dir sync", dir, 0);
    $display("test modes done");
    stop_test();
  end
endmodule // ulpi_phy_bus_protocol_test
